// [logic/param_card_transfer_ctrl.sv]
// Command interpreter moving parameter sets between drive and memory card
`timescale 1ns/1ps
module param_card_transfer_ctrl
	import card_xfer_pkg::*;
#(
	parameter logic [2:0] FULL_BYTES = 3'h4 // Bytes per full-set entry
)
(
	input  wire logic              clk_sys,
	input  wire logic              reset_n,
	// Register port
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [DATA_W-1:0] reg_rdata,
	// Drive reset request, triggers the command
	input  wire logic              drive_reset,
	// Card slot pin
	input  wire logic              card_present_pin,
	// Card engine status
	input  wire logic       [15:0] card_cap_pages,
	input  wire logic              card_ro,
	input  wire logic              card_sup,
	input  wire logic              card_exists,
	input  wire logic              card_done,
	input  wire logic              card_fail,
	input  wire logic              card_fmt_diff,
	input  wire logic        [2:0] card_slot_diff,
	input  wire logic              card_volt_diff,
	input  wire logic              card_curr_diff,
	input  wire logic              card_file_full,
	// Card engine command
	output logic                   card_start,
	output logic                   card_active,
	output card_op_e               card_op,
	output logic             [9:0] card_block,
	output logic                   card_boot,
	output logic                   card_overwrite,
	// Parameter entry stream
	input  wire logic              par_valid,
	input  wire logic        [7:0] par_menu,
	input  wire logic        [7:0] par_idx,
	input  wire logic              par_ks,
	input  wire logic              par_pds,
	input  wire logic              par_nc,
	input  wire logic              par_sb,
	input  wire logic              par_changed,
	output logic                   par_ready,
	output logic                   apply_valid,
	output logic             [7:0] apply_menu,
	output logic             [7:0] apply_idx,
	output logic             [2:0] apply_len,
	// Drive side results
	output logic                   nv_save,
	output logic             [2:0] slot_default,
	output logic                   busy
);

	// ==========================================
	// State
	typedef struct packed {
		logic              pres1;     // Presence sync, first stage
		logic              pres2;     // Presence sync, second stage
		logic [13:0]       cmd;       // command_entry_parameter
		logic [1:0]        mode;      // Card mode
		trip_e             trip;      // Latched trip
		xfer_state_e       state;     // Sequencer
		card_op_e          op;        // Operation in hand
		logic [9:0]        blk;       // Block in hand
		logic              boot;      // Bootable block
		logic              ovw;       // Overwrite allowed
		logic              from_mode; // Started by card mode
		logic              start;     // Engine start pulse
		logic              active;    // Card access window
		logic              ready;     // Stream ready
		logic              apv;       // Entry out
		logic [7:0]        apm;       // Entry menu
		logic [7:0]        api;       // Entry index
		logic [2:0]        apl;       // Entry length
		logic              nv;        // Save pulse
		logic [2:0]        slots;     // Slots left at defaults
		logic [DATA_W-1:0] rdata;     // Read data
	} state_s;

	state_s   q;         // Registered state
	state_s   d;         // Next state
	card_op_e dec_op;    // Decoded operation
	logic     dec_boot;  // Decoded bootable flag
	logic [9:0] dec_blk; // Decoded block
	logic [3:0] digit;   // Leading digit
	logic     is_write;  // Operation writes or erases
	logic     is_store;  // Operation stores a block
	logic     blk_op;    // Operation names a block
	logic     take;      // Filter decision

	// ==========================================
	// Code decoding
	// Leading digit picks the action, the rest the block
	always_comb
	begin
		digit    = 4'(q.cmd / CODE_DIV);
		dec_blk  = 10'(q.cmd % CODE_DIV);
		dec_boot = 1'b0;
		case (digit)
			4'h2:
			begin
				// Only 2001 is defined in the 2000 range
				dec_op   = (q.cmd == CODE_BOOT_DIFF) ? OP_STORE_DIFF : OP_NONE;
				dec_boot = (q.cmd == CODE_BOOT_DIFF);
			end
			4'h3: dec_op = OP_STORE_FULL;
			4'h4: dec_op = OP_STORE_DIFF;
			4'h5: dec_op = OP_STORE_PROG;
			4'h6: dec_op = OP_READ;
			4'h7: dec_op = OP_ERASE;
			4'h8: dec_op = OP_COMPARE;
			4'h9:
			begin
				// Card wide codes
				case (q.cmd)
					CODE_CLR_SUP:   dec_op = OP_CLR_SUP;
					CODE_SET_SUP:   dec_op = OP_SET_SUP;
					CODE_CLR_RO:    dec_op = OP_CLR_RO;
					CODE_SET_RO:    dec_op = OP_SET_RO;
					CODE_ERASE_ALL: dec_op = OP_ERASE_ALL;
					default:        dec_op = OP_NONE;
				endcase
			end
			default: dec_op = OP_NONE;
		endcase
	end

	// Operation classes
	assign is_store = (q.op == OP_STORE_FULL) || (q.op == OP_STORE_DIFF)
		|| (q.op == OP_STORE_PROG);
	assign is_write = is_store || (q.op == OP_ERASE) || (q.op == OP_ERASE_ALL);
	assign blk_op   = is_store || (q.op == OP_READ) || (q.op == OP_ERASE)
		|| (q.op == OP_COMPARE);

	// ==========================================
	// Entry filter
	param_filter u_filter (
		.op_full   (q.op == OP_STORE_FULL),
		.op_diff   (q.op == OP_STORE_DIFF),
		.op_read   (q.op == OP_READ),
		.file_full (card_file_full),
		.volt_diff (card_volt_diff),
		.curr_diff (card_curr_diff),
		.menu      (par_menu),
		.idx       (par_idx),
		.ks        (par_ks),
		.pds       (par_pds),
		.nc        (par_nc),
		.sb        (par_sb),
		.changed   (par_changed),
		.take      (take)
	);

	// ==========================================
	// Next state
	always_comb
	begin
		d       = q;
		d.pres1 = card_present_pin;
		d.pres2 = q.pres1;
		d.start = 1'b0;
		d.apv   = 1'b0;
		d.nv    = 1'b0;
		d.rdata = '0;
		// Register writes; hardware trips below win over a clear
		if (reg_wr)
		begin
			case (reg_addr)
				OFS_CMD:  d.cmd  = reg_wdata[13:0];
				OFS_MODE: d.mode = reg_wdata[1:0];
				OFS_TRIP: d.trip = TRIP_NONE;
				default:  ;
			endcase
		end
		// Register reads, unmapped read as zero
		if (reg_rd)
		begin
			case (reg_addr)
				OFS_CMD:  d.rdata[13:0] = q.cmd;
				OFS_MODE: d.rdata[1:0]  = q.mode;
				OFS_TRIP: d.rdata[3:0]  = q.trip;
				OFS_STAT:
				begin
					d.rdata[STAT_BUSY]    = (q.state != ST_IDLE);
					d.rdata[STAT_PRESENT] = q.pres2;
					d.rdata[STAT_RO]      = card_ro;
					d.rdata[STAT_SUP]     = card_sup;
				end
				default:  ;
			endcase
		end
		// Sequencer
		case (q.state)
			ST_IDLE:
			begin
				// Drive reset picks up the pending command
				if (drive_reset)
				begin
					d.from_mode = 1'b0;
					if (q.mode == MODE_PROG)
					begin
						// Card mode store into block 1 with overwrite
						d.op        = OP_STORE_FULL;
						d.blk       = BLK_FIRST;
						d.boot      = 1'b0;
						d.ovw       = 1'b1;
						d.from_mode = 1'b1;
						d.state     = ST_CHECK;
					end
					else if (dec_op != OP_NONE)
					begin
						d.op    = dec_op;
						d.blk   = dec_boot ? BLK_FIRST : dec_blk;
						d.boot  = dec_boot;
						d.ovw   = dec_boot;
						d.state = ST_CHECK;
					end
				end
			end
			ST_CHECK:
			begin
				d.state = ST_IDLE;
				if (!q.pres2)
					d.trip = TRIP_CARD;
				else if (card_cap_pages < CAP_MIN_PG || card_cap_pages > CAP_MAX_PG)
					d.trip = TRIP_CARD;
				else if (card_ro && is_write)
					d.trip = TRIP_PROTECT;
				else if (card_ro && q.op != OP_READ && q.op != OP_CLR_RO)
					d.trip = q.trip; // Ignored while protected
				else if (blk_op && (q.blk < BLK_FIRST || q.blk > BLK_LAST))
					d.trip = TRIP_RANGE;
				else if (is_write && q.op != OP_ERASE_ALL && q.blk >= BLK_RO_FIRST)
					d.trip = TRIP_PROTECT;
				else if (is_store && card_exists && !q.ovw)
					d.trip = TRIP_EXISTS;
				else
				begin
					// Open the card window and start the engine
					d.start  = 1'b1;
					d.active = 1'b1;
					d.ready  = is_store || (q.op == OP_READ);
					d.state  = ST_XFER;
				end
			end
			ST_XFER:
			begin
				// Filtered entries pass to the store or the drive
				if (q.ready && par_valid && take)
				begin
					d.apv = 1'b1;
					d.apm = par_menu;
					d.api = par_idx;
					d.apl = (q.op == OP_STORE_DIFF) ? DIFF_BYTES : FULL_BYTES;
				end
				if (!q.pres2)
				begin
					// Card pulled out, abandon the transfer
					d.trip   = TRIP_REMOVED;
					d.active = 1'b0;
					d.ready  = 1'b0;
					d.state  = ST_IDLE;
				end
				else if (card_done)
				begin
					d.active = 1'b0;
					d.ready  = 1'b0;
					d.state  = ST_IDLE;
					if (q.from_mode)
						d.mode = MODE_NONE;
					if (q.op == OP_COMPARE)
					begin
						// Other block formats never compare equal
						if (card_fail || card_fmt_diff)
							d.trip = TRIP_COMPARE;
						else
							d.cmd = CMD_RESET;
					end
					else if (card_fail)
						d.trip = TRIP_FAIL;
					else if (q.op == OP_READ)
					begin
						// Into working and nonvolatile memory at once
						d.nv    = 1'b1;
						d.slots = card_slot_diff;
						if (card_slot_diff != 3'h0 && !card_sup)
							d.trip = TRIP_OPTION;
						else if ((card_volt_diff || card_curr_diff) && !card_sup)
							d.trip = TRIP_RATING;
					end
				end
			end
			default: d.state = ST_IDLE;
		endcase
	end

	// ==========================================
	// State register
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			q       <= '0;
			q.trip  <= TRIP_NONE;
			q.state <= ST_IDLE;
			q.op    <= OP_NONE;
		end
		else
			q <= d;
	end

	// ==========================================
	// Outputs
	assign reg_rdata      = q.rdata;
	assign card_start     = q.start;
	assign card_active    = q.active;
	assign card_op        = q.op;
	assign card_block     = q.blk;
	assign card_boot      = q.boot;
	assign card_overwrite = q.ovw;
	assign par_ready      = q.ready;
	assign apply_valid    = q.apv;
	assign apply_menu     = q.apm;
	assign apply_idx      = q.api;
	assign apply_len      = q.apl;
	assign nv_save        = q.nv;
	assign slot_default   = q.slots;
	assign busy           = q.active;

	// ==========================================
	// Assertions
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	// Mode 2 trigger
	sequence s_mode_trig;
		q.state == ST_IDLE && drive_reset && q.mode == MODE_PROG;
	endsequence

	// Transfer finishing on a present card
	sequence s_done(card_op_e op);
		q.state == ST_XFER && q.pres2 && card_done && q.op == op;
	endsequence

	AST_MODE_BLK1: assert property (
		s_mode_trig |=> q.op == OP_STORE_FULL && q.blk == BLK_FIRST && q.ovw)
		else $error("Card mode store not aimed at block 1");

	AST_MODE_BACK: assert property (
		q.state == ST_XFER && q.pres2 && card_done && q.from_mode
		|=> q.mode == MODE_NONE && q.state == ST_IDLE)
		else $error("Card mode not returned to zero");

	AST_WINDOW: assert property (
		card_active |-> q.state == ST_XFER && $past(q.state) != ST_IDLE)
		else $error("Card accessed outside a transfer");

	AST_REMOVED: assert property (
		q.state == ST_XFER && !q.pres2 |=> q.trip == TRIP_REMOVED && !card_active)
		else $error("Card removal not tripped");

	AST_PROTECT: assert property (
		q.state == ST_CHECK && q.pres2 && card_ro && is_write
		&& card_cap_pages >= CAP_MIN_PG && card_cap_pages <= CAP_MAX_PG
		|=> q.trip == TRIP_PROTECT && !card_start)
		else $error("Protected write not tripped");

	AST_RO_OPS: assert property (
		card_start && $past(card_ro) |-> card_op == OP_READ || card_op == OP_CLR_RO)
		else $error("Operation started on protected card");

	AST_CMP_OK: assert property (
		s_done(OP_COMPARE) ##0 (!card_fail && !card_fmt_diff) |=> q.cmd == CMD_RESET)
		else $error("Good compare left command set");

	AST_READ_NV: assert property (
		s_done(OP_READ) ##0 !card_fail |=> nv_save ##1 !nv_save)
		else $error("Read did not save to nonvolatile memory");

	AST_ONE_CMD: assert property (
		q.state != ST_IDLE |=> $stable(q.op) && $stable(q.blk))
		else $error("Command replaced during transfer");

	AST_BLK_RANGE: assert property (
		card_start && card_op != OP_ERASE_ALL && card_op != OP_SET_RO
		&& card_op != OP_CLR_RO && card_op != OP_SET_SUP && card_op != OP_CLR_SUP
		|-> card_block >= BLK_FIRST && card_block <= BLK_LAST)
		else $error("Block number out of range");

	AST_DIFF_LEN: assert property (
		apply_valid && card_op == OP_STORE_DIFF |-> apply_len == DIFF_BYTES)
		else $error("Difference entry not six bytes");

endmodule // param_card_transfer_ctrl

// [logic/card_xfer_pkg.sv]
// Shared constants and types of the parameter card transfer controller
package card_xfer_pkg;

	// ==========================================
	// Register bus and map
	localparam int         ADDR_W   = 4;
	localparam int         DATA_W   = 32;
	localparam logic [3:0] OFS_CMD  = 4'h0; // Command entry, read/write
	localparam logic [3:0] OFS_MODE = 4'h4; // Card mode, read/write
	localparam logic [3:0] OFS_STAT = 4'h8; // Status, read only
	localparam logic [3:0] OFS_TRIP = 4'hC; // Trip code, write clears

	// Status bit positions
	localparam int STAT_BUSY    = 0;
	localparam int STAT_PRESENT = 1;
	localparam int STAT_RO      = 2;
	localparam int STAT_SUP     = 3;

	// ==========================================
	// Command codes (decimal values in comments)
	localparam logic [13:0] CODE_BOOT_DIFF = 14'h07D1; // 2001
	localparam logic [13:0] CODE_CLR_SUP   = 14'h2553; // 9555
	localparam logic [13:0] CODE_SET_SUP   = 14'h25C2; // 9666
	localparam logic [13:0] CODE_CLR_RO    = 14'h2631; // 9777
	localparam logic [13:0] CODE_SET_RO    = 14'h26A0; // 9888
	localparam logic [13:0] CODE_ERASE_ALL = 14'h270F; // 9999
	localparam logic [13:0] CODE_DIV      = 14'h03E8; // 1000
	localparam logic [13:0] CMD_RESET     = 14'h0000;

	// ==========================================
	// Block numbering and card size
	localparam logic [9:0]  BLK_FIRST    = 10'h001; // 1
	localparam logic [9:0]  BLK_LAST     = 10'h3E7; // 999
	localparam logic [9:0]  BLK_RO_FIRST = 10'h1F4; // 500
	localparam int          CARD_MIN_KB  = 4;
	localparam int          CARD_MAX_KB  = 512;
	localparam int          PAGE_BYTES   = 16;
	localparam logic [15:0] CAP_MIN_PG   = 16'(CARD_MIN_KB * 1024 / PAGE_BYTES);
	localparam logic [15:0] CAP_MAX_PG   = 16'(CARD_MAX_KB * 1024 / PAGE_BYTES);

	// ==========================================
	// Modes, sizes and the user menu
	localparam logic [1:0] MODE_NONE  = 2'h0;
	localparam logic [1:0] MODE_PROG  = 2'h2;
	localparam logic [2:0] DIFF_BYTES = 3'h6; // Bytes per changed entry
	localparam logic [7:0] MENU_USER  = 8'h14; // Menu 20

	// Card operations issued to the card engine
	typedef enum logic [3:0] {
		OP_NONE, OP_STORE_FULL, OP_STORE_DIFF, OP_STORE_PROG, OP_READ,
		OP_ERASE, OP_ERASE_ALL, OP_COMPARE, OP_SET_SUP, OP_CLR_SUP,
		OP_SET_RO, OP_CLR_RO
	} card_op_e;

	// Trip codes shown in the trip register
	typedef enum logic [3:0] {
		TRIP_NONE, TRIP_PROTECT, TRIP_EXISTS, TRIP_COMPARE, TRIP_OPTION,
		TRIP_RATING, TRIP_REMOVED, TRIP_RANGE, TRIP_CARD, TRIP_FAIL
	} trip_e;

	// Sequencer states
	typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_XFER} xfer_state_e;

endpackage

// [logic/param_filter.sv]
// Per-entry decision whether a parameter travels to or from the card
`timescale 1ns/1ps
module param_filter
	import card_xfer_pkg::*;
(
	input  wire logic       op_full,    // Full-set store
	input  wire logic       op_diff,    // Difference store
	input  wire logic       op_read,    // Card to drive
	input  wire logic       file_full,  // Card file is a full set
	input  wire logic       volt_diff,  // Voltage rating differs
	input  wire logic       curr_diff,  // Current rating differs
	input  wire logic [7:0] menu,       // Menu number
	input  wire logic [7:0] idx,        // Index in menu
	input  wire logic       ks,         // kept_setting_flag
	input  wire logic       pds,        // power_down_save_flag
	input  wire logic       nc,         // Not-copied flag
	input  wire logic       sb,         // size_bound_flag
	input  wire logic       changed,    // Differs from defaults
	output logic            take        // Entry is transferred
);

	// ==========================================
	// Selection
	logic user_menu; // Menu 20, command entry excluded
	logic rated;     // Rating bound entry with rating mismatch

	// Menu 20 entries ride along in difference files
	assign user_menu = (menu == MENU_USER) && (idx != 8'h00);
	assign rated     = sb && (volt_diff || curr_diff);

	// Decision per operation
	always_comb
	begin
		take = 1'b0;
		if (op_full)
			take = ks && !nc && !pds;
		else if (op_diff)
			take = !pds && changed && ((ks && !nc) || user_menu);
		else if (op_read)
			// Full sets drop rated entries, diff sets keep them on current only
			take = !rated || (!file_full && !volt_diff);
	end

endmodule // param_filter

// [bench/card_model.sv]
// Behavioural memory card engine answering the controller's start requests
`timescale 1ns/1ps
module card_model
	import card_xfer_pkg::*;
#(
	parameter int LAT = 10 // Cycles from the end of the start pulse to done
)
(
	input  wire logic clk_sys,
	input  wire logic reset_n,
	input  wire logic card_start,
	input  wire logic card_active,
	input  wire logic bad,         // Answer the access with a failure
	output logic      card_done,
	output logic      card_fail
);
	// ==========================================
	// Access timer
	int cnt; // Cycles left in the running access

	// Counts an access down; a closed window abandons it, no late done
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cnt       <= 0;
			card_done <= 1'b0;
			card_fail <= 1'b0;
		end
		else
		begin
			card_done <= 1'b0;
			card_fail <= 1'b0;
			if (card_start)
				cnt <= LAT;
			else if (!card_active)
				cnt <= 0;
			else if (cnt == 1)
			begin
				cnt       <= 0;
				card_done <= 1'b1;
				card_fail <= bad;
			end
			else if (cnt > 1)
				cnt <= cnt - 1;
		end
	end
endmodule // card_model

// [bench/param_card_transfer_ctrl_tb.sv]
// Self-checking bench of the card transfer command interpreter
`timescale 1ns/1ps
module param_card_transfer_ctrl_tb
	import card_xfer_pkg::*;
;
	// ==========================================
	// Signals
	localparam logic [2:0] FB = 3'h5; // Full-set entry size under test
	logic        clk_sys, reset_n, reg_wr, reg_rd, drive_reset, card_present_pin;
	logic        card_ro, card_sup, card_exists, card_done, card_fail, card_fmt_diff;
	logic        card_volt_diff, card_curr_diff, card_file_full, par_valid, par_ks, par_pds;
	logic        par_nc, par_sb, par_changed, card_start, card_active, card_boot;
	logic        card_overwrite, par_ready, apply_valid, nv_save, busy, bad, pull, boot, ovw;
	logic [3:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, d;
	logic [15:0] card_cap_pages;
	logic [9:0]  card_block;
	logic [7:0]  par_menu, par_idx, apply_menu, apply_idx, am, ai;
	logic [2:0]  card_slot_diff, apply_len, slot_default, len;
	card_op_e    card_op;
	int          n_fail, checked, n_st, n_ap, n_nv, nv0, cyc;
	logic [13:0] codes [7] = '{14'd5005, 14'd7005, 14'd9999, 14'd9666, 14'd9555, 14'd9888,
		14'd9777};
	card_op_e    ops [7] = '{OP_STORE_PROG, OP_ERASE, OP_ERASE_ALL, OP_SET_SUP, OP_CLR_SUP,
		OP_SET_RO, OP_CLR_RO};

	// ==========================================
	// Design, card and clock
	param_card_transfer_ctrl #(.FULL_BYTES(FB)) dut (.clk_sys, .reset_n, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .drive_reset, .card_present_pin, .card_cap_pages, .card_ro,
		.card_sup, .card_exists, .card_done, .card_fail, .card_fmt_diff, .card_slot_diff,
		.card_volt_diff, .card_curr_diff, .card_file_full, .card_start, .card_active, .card_op,
		.card_block, .card_boot, .card_overwrite, .par_valid, .par_menu, .par_idx, .par_ks,
		.par_pds, .par_nc, .par_sb, .par_changed, .par_ready, .apply_valid, .apply_menu,
		.apply_idx, .apply_len, .nv_save, .slot_default, .busy);
	card_model card (.clk_sys, .reset_n, .card_start, .card_active, .bad, .card_done, .card_fail);

	initial
	begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// Counts starts, entries and saves; cuts a hang short
	always @(posedge clk_sys)
	begin
		cyc++;
		if (card_start === 1'b1)
		begin
			n_st++;
			boot = card_boot;
			ovw = card_overwrite;
		end
		if (apply_valid === 1'b1)
		begin
			n_ap++;
			len = apply_len;
			am = apply_menu;
			ai = apply_idx;
		end
		if (nv_save === 1'b1)
			n_nv++;
		if (cyc == 4000)
		begin
			n_fail++;
			stop_test();
		end
	end

	// ==========================================
	// Tasks
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("wrong value %s exp %h got %h", what, exp, got);
		end
	endtask

	// One-cycle write strobe
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_wr    <= 1'b1;
		@(posedge clk_sys);
		reg_wr    <= 1'b0;
	endtask

	// One-cycle read strobe, data taken in the following cycle
	task automatic rd(input logic [3:0] a);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk_sys);
		reg_rd   <= 1'b0;
		#1 d = reg_rdata;
	endtask

	// Code, drive reset, one entry offered, repeat reset while busy, trip read back
	task automatic cmd(input logic [13:0] code, input card_op_e op, input logic [9:0] blk,
		input trip_e trip, input logic [31:0] n_entry);
		int st0;
		int ap0;
		logic rdy;
		wr(OFS_TRIP, 32'h0000_0000);
		wr(OFS_CMD, {18'h0, code});
		st0 = n_st;
		ap0 = n_ap;
		rdy = op inside {OP_STORE_FULL, OP_STORE_DIFF, OP_STORE_PROG, OP_READ};
		@(posedge clk_sys);
		drive_reset <= 1'b1;
		@(posedge clk_sys);
		drive_reset <= 1'b0;
		repeat (2) @(posedge clk_sys);
		#1;
		if (op != OP_NONE)
			chk("op", 32'(op), 32'(card_op));
		if (op != OP_NONE && blk != 10'h3FF)
			chk("block", 32'(blk), 32'(card_block));
		if (op == OP_NONE)
			chk("busy", 32'h0, 32'(busy));
		chk("active", 32'(op != OP_NONE), 32'(card_active));
		if (op != OP_NONE)
			chk("ready", 32'(rdy), 32'(par_ready));
		@(posedge clk_sys);
		par_valid   <= 1'b1;
		drive_reset <= (op != OP_NONE);
		if (pull)
			card_present_pin <= 1'b0;
		@(posedge clk_sys);
		par_valid   <= 1'b0;
		drive_reset <= 1'b0;
		for (int i = 0; i < 40 && busy !== 1'b0; i++)
			@(posedge clk_sys);
		rd(OFS_TRIP);
		chk("trip", 32'(trip), d);
		chk("starts", 32'(op != OP_NONE), 32'(n_st - st0));
		if (n_entry != 32'hFFFF_FFFF)
			chk("entries", n_entry, 32'(n_ap - ap0));
	endtask

	task automatic stop_test();
		if (n_fail == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ==========================================
	// Main sequence
	initial
	begin
		{reset_n, reg_wr, reg_rd, drive_reset, card_ro, card_sup, card_exists, card_fmt_diff,
			card_volt_diff, card_curr_diff, card_file_full, par_valid, par_pds, par_nc, par_sb,
			bad, pull, reg_addr, reg_wdata, card_slot_diff, par_idx} <= '0;
		{card_present_pin, par_ks, par_changed} <= 3'b111;
		card_cap_pages <= 16'h0100;
		par_menu <= 8'h03;
		repeat (3) @(posedge clk_sys);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rd(OFS_STAT);
		chk("stat", 32'h0000_0002, d);
		rd(4'h2);
		chk("unmapped", 32'h0000_0000, d);
		cmd(14'd3005, OP_STORE_FULL, 10'd5, TRIP_NONE, 1);
		chk("len", 32'(FB), 32'(len));
		par_pds <= 1'b1;
		cmd(14'd3006, OP_STORE_FULL, 10'd6, TRIP_NONE, 0);
		par_pds <= 1'b0;
		cmd(14'd4007, OP_STORE_DIFF, 10'd7, TRIP_NONE, 1);
		chk("len", 32'(DIFF_BYTES), 32'(len));
		// Menu 20 entry with a nonzero index rides along, index zero does not
		{par_ks, par_nc, par_menu, par_idx} <= {2'b01, MENU_USER, 8'h05};
		cmd(14'd4008, OP_STORE_DIFF, 10'd8, TRIP_NONE, 1);
		chk("menu", 32'(MENU_USER), 32'(am));
		chk("index", 32'h0000_0005, 32'(ai));
		par_idx <= 8'h00;
		cmd(14'd4009, OP_STORE_DIFF, 10'd9, TRIP_NONE, 0);
		{par_ks, par_nc, par_menu} <= {2'b10, 8'h03};
		cmd(14'd3500, OP_NONE, 10'd0, TRIP_PROTECT, 0);
		cmd(14'd3499, OP_STORE_FULL, 10'd499, TRIP_NONE, 1);
		cmd(14'd3000, OP_NONE, 10'd0, TRIP_RANGE, 0);
		cmd(14'd6999, OP_READ, 10'd999, TRIP_NONE, 1);
		card_exists <= 1'b1;
		cmd(14'd3005, OP_NONE, 10'd0, TRIP_EXISTS, 0);
		cmd(14'd2001, OP_STORE_DIFF, 10'd1, TRIP_NONE, 1);
		chk("boot", 32'h1, 32'({boot, ovw} == 2'b11));
		cmd(14'd2002, OP_NONE, 10'd0, TRIP_NONE, 0);
		wr(OFS_MODE, 32'h0000_0002);
		cmd(14'd0, OP_STORE_FULL, 10'd1, TRIP_NONE, 1);
		chk("ovw", 32'h1, 32'(ovw));
		rd(OFS_MODE);
		chk("mode", 32'h0000_0000, d);
		card_exists <= 1'b0;
		cmd(14'd8005, OP_COMPARE, 10'd5, TRIP_NONE, 0);
		rd(OFS_CMD);
		chk("cmd", 32'h0000_0000, d);
		bad <= 1'b1;
		cmd(14'd8005, OP_COMPARE, 10'd5, TRIP_COMPARE, 0);
		cmd(14'd3005, OP_STORE_FULL, 10'd5, TRIP_FAIL, 1);
		{bad, card_fmt_diff} <= 2'b01;
		cmd(14'd8005, OP_COMPARE, 10'd5, TRIP_COMPARE, 0);
		card_fmt_diff <= 1'b0;
		nv0 = n_nv;
		cmd(14'd6005, OP_READ, 10'd5, TRIP_NONE, 1);
		chk("nv_save", 32'h1, 32'(n_nv - nv0));
		card_slot_diff <= 3'b010;
		cmd(14'd6005, OP_READ, 10'd5, TRIP_OPTION, 1);
		chk("slots", 32'h2, 32'(slot_default));
		{card_slot_diff, card_volt_diff, par_sb, card_file_full} <= 6'b000111;
		cmd(14'd6005, OP_READ, 10'd5, TRIP_RATING, 0);
		{card_volt_diff, card_curr_diff, card_file_full} <= 3'b010;
		cmd(14'd6005, OP_READ, 10'd5, TRIP_RATING, 1);
		card_sup <= 1'b1;
		cmd(14'd6005, OP_READ, 10'd5, TRIP_NONE, 1);
		{card_sup, card_curr_diff, par_sb} <= 3'b000;
		for (int i = 0; i < 7; i++)
			cmd(codes[i], ops[i], 10'h3FF, TRIP_NONE, 32'hFFFF_FFFF);
		card_ro <= 1'b1;
		cmd(14'd3005, OP_NONE, 10'd0, TRIP_PROTECT, 0);
		cmd(14'd7005, OP_NONE, 10'd0, TRIP_PROTECT, 0);
		cmd(14'd9888, OP_NONE, 10'd0, TRIP_NONE, 0);
		cmd(14'd6005, OP_READ, 10'd5, TRIP_NONE, 1);
		cmd(14'd9777, OP_CLR_RO, 10'h3FF, TRIP_NONE, 32'hFFFF_FFFF);
		card_ro <= 1'b0;
		card_cap_pages <= 16'h00FF;
		cmd(14'd3005, OP_NONE, 10'd0, TRIP_CARD, 0);
		card_cap_pages <= 16'h8001;
		cmd(14'd3005, OP_NONE, 10'd0, TRIP_CARD, 0);
		card_cap_pages <= 16'h8000;
		cmd(14'd3005, OP_STORE_FULL, 10'd5, TRIP_NONE, 1);
		card_present_pin <= 1'b0;
		cmd(14'd3005, OP_NONE, 10'd0, TRIP_CARD, 0);
		{card_present_pin, pull} <= 2'b11;
		repeat (3) @(posedge clk_sys);
		cmd(14'd3005, OP_STORE_FULL, 10'd5, TRIP_REMOVED, 1);
		stop_test();
	end
endmodule // param_card_transfer_ctrl_tb
